// ===== hw/hpsf_pkg.sv
// Purpose: Constants and types for the host port status word.
// Assumes: One 100 MHz clock; all flag sources but the two synchronised pins on that clock.
// Notes:   Bit positions below are those of the status word and the routing register.
//
// Contract
// - Status word reachable by external host only
// - Host status read makes no memory cycle
// - Bit 15 high when bus power above threshold
// - Bit 14 shows the role pin level
// - Bits 12 and 10 show frame marker events
// - Bits 9 and 1 show bus reset events
// - Bits 7 and 6 show wakeup events
// - Bit 8 set by host mailbox write, CPU read clears
// - Bit 0 set by CPU mailbox write, host read clears
// - Bits 5 and 4 set by message writes, host read clears
// - Host mode: bits 3 and 2 show packet done
// - Peripheral mode: completion is OR of endpoints
// - Engine events appear only when routed to host
// - Message register write raises flag and irq
// - CPU mailbox write raises irq, host read drops it
package hpsf_pkg;

  localparam int STATUS_W = 16;
  localparam int EP_COUNT = 8;

  // ----------------------------------------------------------------
  // Status word bit positions
  // ----------------------------------------------------------------
  localparam int B_POWER  = 15;
  localparam int B_ROLE   = 14;
  localparam int B_FRAME2 = 12;
  localparam int B_FRAME1 = 10;
  localparam int B_RST2   = 9;
  localparam int B_MB_IN  = 8;
  localparam int B_WAKE2  = 7;
  localparam int B_WAKE1  = 6;
  localparam int B_MSG2   = 5;
  localparam int B_MSG1   = 4;
  localparam int B_DONE2  = 3;
  localparam int B_DONE1  = 2;
  localparam int B_RST1   = 1;
  localparam int B_MB_OUT = 0;

  // ----------------------------------------------------------------
  // Routing register bit positions
  // ----------------------------------------------------------------
  localparam int R_FRAME2 = 13;
  localparam int R_FRAME1 = 11;
  localparam int R_RST2   = 9;
  localparam int R_WAKE2  = 7;
  localparam int R_WAKE1  = 6;
  localparam int R_DONE2  = 3;
  localparam int R_DONE1  = 2;
  localparam int R_RST1   = 1;

  localparam logic [STATUS_W-1:0] STATUS_RESET = 16'h0000;

  // Settling time after bus power switch-on, for firmware
  localparam real POWER_SETTLE_US = 10.0;
  localparam real CLK_MHZ         = 100.0;
  localparam int  POWER_SETTLE_CYC = int'(POWER_SETTLE_US * CLK_MHZ);

  // Pending latches of one serial engine
  typedef struct packed {
    logic                bus_reset;
    logic                wakeup;
    logic                frame_marker;
    logic                host_mode;
    logic                host_done;
    logic [EP_COUNT-1:0] ep_pending;
  } hpsf_engine_t;

  // Mailbox and message strobes, one-cycle pulses
  typedef struct packed {
    logic host_mbox_wr;
    logic host_mbox_rd;
    logic cpu_mbox_wr;
    logic cpu_mbox_rd;
    logic cpu_msg1_wr;
    logic cpu_msg2_wr;
  } hpsf_strobe_t;

endpackage

// ===== hw/hpsf_status_port.sv
// Purpose: Host port status word, mailbox and message flags, irq.
// Assumes: Strobes and engine latches come from logic on clk.
// Notes:   Only the host port read path reaches the word.
`timescale 1ns/1ns
module hpsf_status_port #(
  parameter int EP_COUNT = hpsf_pkg::EP_COUNT
) (
  input  wire logic                          clk,
  input  wire logic                          reset_n,
  input  wire logic                          power_above_pin,
  input  wire logic                          otg_role_pin,
  input  wire hpsf_pkg::hpsf_engine_t        engine1,
  input  wire hpsf_pkg::hpsf_engine_t        engine2,
  input  wire logic [15:0]                   route_enable,
  input  wire hpsf_pkg::hpsf_strobe_t        strobe,
  input  wire logic                          host_status_rd,
  output logic [hpsf_pkg::STATUS_W-1:0]      host_status_data,
  output logic                               host_port_irq
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [1:0] pins_sync;

  hpsf_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in ({power_above_pin, otg_role_pin}),
    .sync_out (pins_sync)
  );

  wire bus_power_valid_flag = pins_sync[1];
  wire otg_role_pin_flag    = pins_sync[0];

  // ----------------------------------------------------------------
  // Completion decode
  // ----------------------------------------------------------------
  // Host mode uses packet done; peripheral mode any endpoint
  function automatic logic completion(hpsf_pkg::hpsf_engine_t e);
    completion = e.host_mode ? e.host_done
                             : (|e.ep_pending);
  endfunction

  // Events gated by routing; unrouted events belong to the CPU
  wire port1_bus_reset_flag = engine1.bus_reset &
                              route_enable[hpsf_pkg::R_RST1];
  wire port2_bus_reset_flag = engine2.bus_reset &
                              route_enable[hpsf_pkg::R_RST2];
  wire port1_wakeup_flag    = engine1.wakeup &
                              route_enable[hpsf_pkg::R_WAKE1];
  wire port2_wakeup_flag    = engine2.wakeup &
                              route_enable[hpsf_pkg::R_WAKE2];
  wire port1_frame_marker_flag = engine1.frame_marker &
                                 route_enable[hpsf_pkg::R_FRAME1];
  wire port2_frame_marker_flag = engine2.frame_marker &
                                 route_enable[hpsf_pkg::R_FRAME2];
  wire port1_completion_flag = completion(engine1) &
                               route_enable[hpsf_pkg::R_DONE1];
  wire port2_completion_flag = completion(engine2) &
                               route_enable[hpsf_pkg::R_DONE2];
  // Levels above follow the latches directly

  // ----------------------------------------------------------------
  // Mailbox and message flags
  // ----------------------------------------------------------------
  logic mailbox_in_flag;
  logic mailbox_out_flag;
  logic engine1_message_flag;
  logic engine2_message_flag;

  // Set wins over clear so a same-cycle event is kept
  wire next_mailbox_in = strobe.host_mbox_wr |
                         (mailbox_in_flag & ~strobe.cpu_mbox_rd);
  wire next_mailbox_out = strobe.cpu_mbox_wr |
                          (mailbox_out_flag & ~strobe.host_mbox_rd);
  wire next_msg1 = strobe.cpu_msg1_wr |
                   (engine1_message_flag & ~host_status_rd);
  wire next_msg2 = strobe.cpu_msg2_wr |
                   (engine2_message_flag & ~host_status_rd);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mailbox_in_flag      <= 1'b0;
      mailbox_out_flag     <= 1'b0;
      engine1_message_flag <= 1'b0;
      engine2_message_flag <= 1'b0;
    end else begin
      mailbox_in_flag      <= next_mailbox_in;
      mailbox_out_flag     <= next_mailbox_out;
      engine1_message_flag <= next_msg1;
      engine2_message_flag <= next_msg2;
    end
  end

  // ----------------------------------------------------------------
  // Status word assembly
  // ----------------------------------------------------------------
  logic [hpsf_pkg::STATUS_W-1:0] next_status;

  always_comb begin
    next_status = hpsf_pkg::STATUS_RESET;
    next_status[hpsf_pkg::B_POWER]  = bus_power_valid_flag;
    next_status[hpsf_pkg::B_ROLE]   = otg_role_pin_flag;
    next_status[hpsf_pkg::B_FRAME2] = port2_frame_marker_flag;
    next_status[hpsf_pkg::B_FRAME1] = port1_frame_marker_flag;
    next_status[hpsf_pkg::B_RST2]   = port2_bus_reset_flag;
    next_status[hpsf_pkg::B_RST1]   = port1_bus_reset_flag;
    next_status[hpsf_pkg::B_MB_IN]  = mailbox_in_flag;
    next_status[hpsf_pkg::B_WAKE2]  = port2_wakeup_flag;
    next_status[hpsf_pkg::B_WAKE1]  = port1_wakeup_flag;
    next_status[hpsf_pkg::B_MSG2]   = engine2_message_flag;
    next_status[hpsf_pkg::B_MSG1]   = engine1_message_flag;
    next_status[hpsf_pkg::B_DONE2]  = port2_completion_flag;
    next_status[hpsf_pkg::B_DONE1]  = port1_completion_flag;
    next_status[hpsf_pkg::B_MB_OUT] = mailbox_out_flag;
  end

  // Irq: outbound mail, messages and routed engine events
  wire next_irq = mailbox_out_flag | engine1_message_flag |
                  engine2_message_flag |
                  port1_bus_reset_flag | port2_bus_reset_flag |
                  port1_wakeup_flag | port2_wakeup_flag |
                  port1_frame_marker_flag | port2_frame_marker_flag |
                  port1_completion_flag | port2_completion_flag;

  // ----------------------------------------------------------------
  // Host port read path
  // ----------------------------------------------------------------
  // Word is refreshed every cycle from local flops, so a host
  // read needs no memory arbitration and costs the CPU nothing.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      host_status_data <= hpsf_pkg::STATUS_RESET;
      host_port_irq    <= 1'b0;
    end else begin
      host_status_data <= next_status;
      host_port_irq    <= next_irq;
    end
  end

endmodule

// ===== hw/hpsf_sync.sv
// Purpose: Two-stage synchroniser for asynchronous pin levels.
// Assumes: Inputs are slow levels; no pulse capture needed.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/1ns
module hpsf_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// ===== test/hpsf_host_model.sv
// Purpose: External host that polls the status word.
// Assumes: Called 1 ns after an edge; read is a one-cycle pulse.
// Notes:   The gap argument lets the host poll slowly or back to back.
`timescale 1ns/1ns
module hpsf_host_model (
  input  wire logic        clk,
  input  wire logic [15:0] status_data,
  output logic             status_rd
);
  initial status_rd = 1'b0;
  // Word is taken in the cycle its read pulse is sampled
  task automatic read_word(input int gap, output logic [15:0] d);
    repeat (gap) begin
      @(posedge clk);
      #1;
    end
    status_rd = 1'b1;
    d = status_data;
    @(posedge clk);
    #1 status_rd = 1'b0;
  endtask
endmodule

// ===== test/hpsf_status_port_sva.sv
// Purpose: Port-level assertions for the host port status word.
// Assumes: Strobes show two edges later, latches one edge later.
// Notes:   Latch checks wait a few edges after reset release.
`timescale 1ns/1ns
module hpsf_checker #(
  parameter int EP_COUNT = 8
) (
  input wire logic                   clk,
  input wire logic                   reset_n,
  input wire hpsf_pkg::hpsf_engine_t engine1,
  input wire hpsf_pkg::hpsf_engine_t engine2,
  input wire logic [15:0]            route_enable,
  input wire hpsf_pkg::hpsf_strobe_t strobe,
  input wire logic                   host_status_rd,
  input wire logic [15:0]            host_status_data,
  input wire logic                   host_port_irq
);
  logic [1:0] up;
  wire        live = up == 2'h3;
  wire [15:0] d = host_status_data;
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n) up <= 2'h0;
    else if (!live) up <= up + 2'h1;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  property p_msg_set; strobe.cpu_msg2_wr |-> ##2 d[5] && host_port_irq;
  endproperty
  a_msg_set: assert property (p_msg_set) else $error("msg up");
  property p_msg_clr; host_status_rd && !strobe.cpu_msg1_wr
    ##1 !strobe.cpu_msg1_wr |=> !d[4]; endproperty
  a_msg_clr: assert property (p_msg_clr) else $error("msg dn");
  property p_mbo_set; strobe.cpu_mbox_wr |-> ##2 d[0] && host_port_irq;
  endproperty
  a_mbo_set: assert property (p_mbo_set) else $error("mbo up");
  property p_mbo_clr; strobe.host_mbox_rd && !strobe.cpu_mbox_wr
    ##1 !strobe.cpu_mbox_wr |=> !d[0]; endproperty
  a_mbo_clr: assert property (p_mbo_clr) else $error("mbo dn");
  property p_mbi_set; strobe.host_mbox_wr |-> ##2 d[8]; endproperty
  a_mbi_set: assert property (p_mbi_set) else $error("mbi up");
  property p_rst1; live |-> d[1] == $past(engine1.bus_reset & route_enable[1]);
  endproperty
  a_rst1: assert property (p_rst1) else $error("reset1");
  property p_frm2;
    live |-> d[12] == $past(engine2.frame_marker & route_enable[13]);
  endproperty
  a_frm2: assert property (p_frm2) else $error("frame2");
  property p_done1; live |-> d[2] == $past(route_enable[2]
    & (engine1.host_mode ? engine1.host_done : |engine1.ep_pending));
  endproperty
  a_done1: assert property (p_done1) else $error("done1");
  c_msg: cover property (strobe.cpu_msg1_wr ##2 host_port_irq);
  c_clr: cover property (host_status_rd ##2 !host_port_irq);
  c_evt: cover property (live && d[2] && host_port_irq);
endmodule

bind hpsf_status_port hpsf_checker #(.EP_COUNT(EP_COUNT)) i_chk (
  .clk, .reset_n, .engine1, .engine2, .route_enable, .strobe,
  .host_status_rd, .host_status_data, .host_port_irq
);

// ===== test/hpsf_status_port_test.sv
// Purpose: Self-checking bench for the host port status word.
// Assumes: Inputs move 1 ns after rising edges; fixed latencies.
// Notes:   Top bit of each expected value is the irq line.
`timescale 1ns/1ns
module hpsf_status_port_test;
  logic                   clk = 1'b0;
  logic                   reset_n = 1'b0;
  logic                   power_above_pin = 1'b0;
  logic                   otg_role_pin = 1'b0;
  hpsf_pkg::hpsf_engine_t engine1 = '0;
  hpsf_pkg::hpsf_engine_t engine2 = '0;
  logic [15:0]            route_enable = 16'h0000;
  hpsf_pkg::hpsf_strobe_t strobe = '0;
  logic                   host_status_rd;
  logic [15:0]            host_status_data;
  logic                   host_port_irq;
  logic [15:0]            seen;
  int                     err_count = 0;
  int                     comparisons = 0;
  int                     rb[8] = '{13, 11, 9, 7, 6, 3, 2, 1};
  int                     sb[8] = '{12, 10, 9, 7, 6, 3, 2, 1};

  always #5 clk = ~clk;

  hpsf_status_port #(.EP_COUNT(8)) i_dut (
    .clk, .reset_n, .power_above_pin, .otg_role_pin, .engine1, .engine2,
    .route_enable, .strobe, .host_status_rd, .host_status_data,
    .host_port_irq
  );
  hpsf_host_model i_host (
    .clk, .status_data(host_status_data), .status_rd(host_status_rd)
  );

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One-cycle strobe, then one edge for the word to follow
  task automatic fire(input hpsf_pkg::hpsf_strobe_t s);
    strobe = s;
    tick(1);
    strobe = '0;
    tick(1);
  endtask
  function automatic logic [16:0] now();
    return {host_port_irq, host_status_data};
  endfunction
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic ended(input string n);
    $display("test %s ended, errors %0d", n, err_count);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #100000;
    err_count++;
    $display("FAIL %0t run limit", $time);
    report_and_stop();
  end
  // --------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------
  initial begin
    tick(20);
    chk(now(), 17'h00000);
    reset_n = 1'b1;
    tick(2);
    ended("reset");
    fire('{cpu_msg1_wr: 1'b1, cpu_msg2_wr: 1'b1,
           default: 1'b0});
    chk(now(), 17'h10030);
    i_host.read_word(0, seen);
    chk({host_port_irq, seen}, 17'h10030);
    tick(1);
    chk(now(), 17'h00000);
    ended("messages");
    fire('{cpu_mbox_wr: 1'b1, default: 1'b0});
    chk(now(), 17'h10001);
    fire('{cpu_mbox_wr: 1'b1, host_mbox_rd: 1'b1,
           default: 1'b0});
    chk(now(), 17'h10001);
    fire('{host_mbox_rd: 1'b1, default: 1'b0});
    chk(now(), 17'h00000);
    fire('{host_mbox_wr: 1'b1, default: 1'b0});
    chk(now(), 17'h00100);
    fire('{cpu_mbox_rd: 1'b1, default: 1'b0});
    chk(now(), 17'h00000);
    ended("mailbox");
    // Mid-run reset must drop a pending flag at once
    fire('{host_mbox_wr: 1'b1, default: 1'b0});
    chk(now(), 17'h00100);
    reset_n = 1'b0;
    tick(1);
    chk(now(), 17'h00000);
    reset_n = 1'b1;
    tick(2);
    chk(now(), 17'h00000);
    ended("reset again");
    engine1 = '{ep_pending: 8'h00, default: 1'b1};
    engine2 = engine1;
    tick(1);
    chk(now(), 17'h00000);
    for (int i = 0; i < 8; i++) begin
      route_enable = 16'h0001 << rb[i];
      tick(1);
      chk(now(), 17'h10000 | (17'h00001 << sb[i]));
    end
    route_enable = 16'h2ACE;
    tick(1);
    chk(now(), 17'h116CE);
    i_host.read_word(2, seen);
    chk({host_port_irq, seen}, 17'h116CE);
    tick(1);
    chk(now(), 17'h116CE);
    engine1.host_mode = 1'b0;
    tick(1);
    chk(now(), 17'h116CA);
    engine1.ep_pending = 8'h80;
    tick(1);
    chk(now(), 17'h116CE);
    engine1 = '0;
    engine2 = '0;
    tick(1);
    chk(now(), 17'h00000);
    ended("events");
    power_above_pin = 1'b1;
    tick(hpsf_pkg::POWER_SETTLE_CYC);
    chk(now(), 17'h08000);
    power_above_pin = 1'b0;
    otg_role_pin = 1'b1;
    tick(4);
    chk(now(), 17'h04000);
    ended("pins");
    report_and_stop();
  end
endmodule
